//--- design/ofd_pkg.sv
// Package: constants, encodings and register map of the operand field decoder
package ofd_pkg;
    // ************************************************************
    // Widths
    // ************************************************************
    localparam int INSN_W   = 16;
    localparam int BANK_W   = 4;
    localparam int TPTR_W   = 21;
    localparam int LATCH_W  = 8;
    localparam int FLAG_W   = 5;
    localparam int ADDR_W   = 12;
    localparam int PADDR_W  = 12;

    // ************************************************************
    // Register map (byte addresses) and reset values
    // ************************************************************
    localparam logic [11:0] OFF_BANK    = 12'h000;
    localparam logic [11:0] OFF_TPTR    = 12'h004;
    localparam logic [11:0] OFF_TLATCH  = 12'h008;
    localparam logic [11:0] OFF_FLAGS   = 12'h00c;
    localparam logic [11:0] OFF_DSTAT   = 12'h010;
    localparam logic [3:0]  RST_BANK    = 4'h0;
    localparam logic [20:0] RST_TPTR    = 21'h000000;
    localparam logic [7:0]  RST_TLATCH  = 8'h00;
    localparam logic [4:0]  RST_FLAGS   = 5'h00;
    localparam logic [3:0]  ACCESS_BANK = 4'h0;

    // ************************************************************
    // Status flag positions
    // ************************************************************
    localparam int FLG_CARRY = 0;
    localparam int FLG_HALF  = 1;
    localparam int FLG_ZERO  = 2;
    localparam int FLG_OVF   = 3;
    localparam int FLG_NEG   = 4;

    // ************************************************************
    // Opcode patterns
    // ************************************************************
    localparam logic [3:0]  OPC_MOVFF  = 4'hc;
    localparam logic [3:0]  OPC_SECOND = 4'hf;
    localparam logic [7:0]  OPC_GOTO   = 8'hef;
    localparam logic [6:0]  OPC_CALL   = 7'h76;
    localparam logic [7:0]  OPC_LDPTR  = 8'hee;
    localparam logic [14:0] OPC_RET    = 15'h0009;
    localparam logic [13:0] OPC_RETI   = 14'h0004;
    localparam logic [11:0] OPC_TBL    = 12'h000;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {
        TPM_NONE     = 2'h0,
        TPM_POST_INC = 2'h1,
        TPM_POST_DEC = 2'h2,
        TPM_PRE_INC  = 2'h3
    } ofd_tpmode_t;

    typedef enum logic [1:0] {
        ST_FIRST  = 2'h1,
        ST_SECOND = 2'h2
    } ofd_state_t;

    typedef enum logic [1:0] {
        PK_MOVFF = 2'h0,
        PK_LIT20 = 2'h1,
        PK_LDPTR = 2'h2
    } ofd_pend_t;
endpackage

//--- design/ofd_table_pointer.sv
// Table pointer register with its four update modes
`timescale 1ns/1ps
module ofd_table_pointer (
    // Clock, reset, enable
    input  wire logic                      clk,
    input  wire logic                      rstn,
    input  wire logic                      ce,
    // Table operation request
    input  wire logic                      step,
    input  wire ofd_pkg::ofd_tpmode_t      mode,
    // Software load
    input  wire logic                      wr_en,
    input  wire logic [ofd_pkg::TPTR_W-1:0] wr_data,
    // Pointer and address used by the last operation
    output logic      [ofd_pkg::TPTR_W-1:0] ptr_ff,
    output logic      [ofd_pkg::TPTR_W-1:0] addr_ff
);
    logic [ofd_pkg::TPTR_W-1:0] nxt_ptr;
    logic [ofd_pkg::TPTR_W-1:0] nxt_addr;

    // Pre-increment uses the bumped pointer, the others the old one
    always_comb
    begin
        nxt_ptr  = ptr_ff;
        nxt_addr = ptr_ff;
        case (mode)
            ofd_pkg::TPM_POST_INC: nxt_ptr = ptr_ff + 21'h1;
            ofd_pkg::TPM_POST_DEC: nxt_ptr = ptr_ff - 21'h1;
            ofd_pkg::TPM_PRE_INC:
            begin
                nxt_ptr  = ptr_ff + 21'h1;
                nxt_addr = ptr_ff + 21'h1;
            end
            default: nxt_ptr = ptr_ff;
        endcase
    end

    // Pointer update; a table operation wins over a software load
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            ptr_ff <= ofd_pkg::RST_TPTR;
        else if (ce && step)
            ptr_ff <= nxt_ptr;
        else if (ce && wr_en)
            ptr_ff <= wr_data;
    end

    // Program memory address presented for the operation
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            addr_ff <= ofd_pkg::RST_TPTR;
        else if (ce && step)
            addr_ff <= nxt_addr;
    end
endmodule // ofd_table_pointer

//--- design/ofd_decoder.sv
// Operand field decoder: field extraction, two-word sequencing, table unit, flags, APB registers
//
// Overview of operation
// - With the RAM access bit at 0 the RAM address uses the access bank, at 1 the bank select register.
// - The three-bit bit-position field selects one of bits 0 to 7 of the addressed 8-bit register.
// - The destination bit sends the result to the working accumulator at 0 and to the file register at 1.
// - The file field is an 8-bit register address, or a 2-bit indirect pointer selector for pointer loads.
// - The memory-to-memory move carries a 12-bit source and a 12-bit destination register address.
// - On calls and returns a fast bit of 1 uses the shadow registers and a 0 leaves them alone.
// - Table reads and writes apply no change, post-increment, post-decrement or pre-increment to the pointer.
// - The table pointer is 21 bits wide and table data passes through an 8-bit table latch.
// - Don't-care bits are ignored by the decoder and should be emitted as zero by code generators.
// - Indexed addressing uses a 7-bit source offset and a separate 7-bit destination offset.
// - Relative branch offsets are two's complement, call and goto targets are absolute.
// - Literals are extracted as 8-bit, 12-bit or 20-bit constants by instruction format.
// - The five status flags carry, half carry, zero, overflow and negative are kept and updated.
// - A second word has ones in its top four bits and behaves as a no-operation when run alone.
`timescale 1ns/1ps
module ofd_decoder (
    // Clock, reset, enable
    input  wire logic                        clk,
    input  wire logic                        rstn,
    input  wire logic                        ce,
    // APB slave
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [ofd_pkg::PADDR_W-1:0] paddr,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    // Instruction word from fetch
    input  wire logic                        insn_valid,
    input  wire logic [ofd_pkg::INSN_W-1:0]  insn,
    // Decoded fields
    output logic                             fields_valid,
    output logic                             nop_word,
    output logic                             second_err,
    output logic [ofd_pkg::ADDR_W-1:0]       ram_addr,
    output logic [7:0]                       file_addr,
    output logic                             dest_is_file,
    output logic [7:0]                       bit_sel,
    output logic [1:0]                       ptr_sel,
    output logic [ofd_pkg::ADDR_W-1:0]       src_addr12,
    output logic [ofd_pkg::ADDR_W-1:0]       dst_addr12,
    output logic [7:0]                       lit8,
    output logic [11:0]                      lit12,
    output logic [19:0]                      lit20,
    output logic [20:0]                      rel_long,
    output logic [20:0]                      rel_short,
    output logic                             fast_mode,
    output logic [6:0]                       src_offset,
    output logic [6:0]                       dst_offset,
    // Table transfer
    output logic                             tbl_req,
    output logic                             tbl_is_write,
    output logic [ofd_pkg::TPTR_W-1:0]       tbl_addr,
    input  wire logic                        tbl_rd_valid,
    input  wire logic [7:0]                  tbl_rd_data,
    output logic [ofd_pkg::LATCH_W-1:0]      table_latch,
    // Status flags
    input  wire logic [ofd_pkg::FLAG_W-1:0]  flag_we,
    input  wire logic [ofd_pkg::FLAG_W-1:0]  flag_in,
    output logic      [ofd_pkg::FLAG_W-1:0]  flags
);
    // ************************************************************
    // Declarations
    // ************************************************************
    ofd_pkg::ofd_state_t     state_ff;
    ofd_pkg::ofd_pend_t      pend_ff;
    logic [ofd_pkg::BANK_W-1:0] bank_ff;
    logic [ofd_pkg::TPTR_W-1:0] tptr;
    logic [11:0]             hold_ff;
    logic                    take;
    logic                    take2;
    logic                    is_second;
    logic                    is_movff;
    logic                    is_goto;
    logic                    is_call;
    logic                    is_ldptr;
    logic                    is_ret;
    logic                    is_tbl;
    logic                    two_word;
    logic                    apb_wr;
    logic                    apb_setup;
    logic                    addr_ok;
    logic [31:0]             nxt_prdata;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    // ************************************************************
    // Opcode recognition
    // ************************************************************
    // Don't-care bits take no part in any comparison below
    assign is_second = insn[15:12] == ofd_pkg::OPC_SECOND;
    assign is_movff  = insn[15:12] == ofd_pkg::OPC_MOVFF;
    assign is_goto   = insn[15:8] == ofd_pkg::OPC_GOTO;
    assign is_call   = insn[15:9] == ofd_pkg::OPC_CALL;
    assign is_ldptr  = insn[15:8] == ofd_pkg::OPC_LDPTR;
    assign is_ret    = (insn[15:1] == ofd_pkg::OPC_RET) || (insn[15:2] == ofd_pkg::OPC_RETI);
    assign is_tbl    = (insn[15:4] == ofd_pkg::OPC_TBL) && insn[3];
    assign two_word  = is_movff || is_goto || is_call || is_ldptr;
    assign take      = ce && insn_valid && (state_ff == ofd_pkg::ST_FIRST);
    assign take2     = ce && insn_valid && (state_ff == ofd_pkg::ST_SECOND);

    // ************************************************************
    // Two-word sequencing
    // ************************************************************
    // Waits for the second word after a two-word opcode
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            state_ff <= ofd_pkg::ST_FIRST;
        else if (ce && insn_valid)
        begin
            case (state_ff)
                ofd_pkg::ST_FIRST:  state_ff <= two_word ? ofd_pkg::ST_SECOND : ofd_pkg::ST_FIRST;
                ofd_pkg::ST_SECOND: state_ff <= ofd_pkg::ST_FIRST;
                default:            state_ff <= ofd_pkg::ST_FIRST;
            endcase
        end
    end

    // Remembers the kind of first word and its low twelve bits
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pend_ff <= ofd_pkg::PK_MOVFF;
            hold_ff <= 12'h000;
        end
        else if (take)
        begin
            pend_ff <= is_movff ? ofd_pkg::PK_MOVFF : (is_ldptr ? ofd_pkg::PK_LDPTR : ofd_pkg::PK_LIT20);
            hold_ff <= insn[11:0];
        end
    end

    // One valid pulse per complete instruction, a lone second word is a no-operation
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            fields_valid <= 1'b0;
            nop_word     <= 1'b0;
            second_err   <= 1'b0;
        end
        else if (ce)
        begin
            fields_valid <= (take && !two_word) || take2;
            nop_word     <= take && is_second;
            second_err   <= take2 && !is_second;
        end
    end

    // ************************************************************
    // First-word fields, all presented in parallel
    // ************************************************************
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ram_addr     <= 12'h000;
            file_addr    <= 8'h00;
            dest_is_file <= 1'b0;
            bit_sel      <= 8'h00;
            ptr_sel      <= 2'h0;
            src_addr12   <= 12'h000;
            lit8         <= 8'h00;
            rel_long     <= 21'h000000;
            rel_short    <= 21'h000000;
            fast_mode    <= 1'b0;
            src_offset   <= 7'h00;
        end
        else if (take)
        begin
            ram_addr     <= insn[8] ? {bank_ff, insn[7:0]} : {ofd_pkg::ACCESS_BANK, insn[7:0]};
            file_addr    <= insn[7:0];
            dest_is_file <= insn[9];
            bit_sel      <= 8'h01 << insn[11:9];
            ptr_sel      <= insn[5:4];
            src_addr12   <= insn[11:0];
            lit8         <= insn[7:0];
            rel_long     <= {{10{insn[10]}}, insn[10:0]};
            rel_short    <= {{13{insn[7]}}, insn[7:0]};
            fast_mode    <= (is_call && insn[8]) || (is_ret && insn[0]);
            src_offset   <= insn[6:0];
        end
    end

    // ************************************************************
    // Second-word fields; lit12 and lit20 also load from the first word
    // ************************************************************
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            dst_addr12 <= 12'h000;
            lit12      <= 12'h000;
            lit20      <= 20'h00000;
            dst_offset <= 7'h00;
        end
        else if (take)
        begin
            lit12 <= insn[11:0];
            lit20 <= {12'h000, insn[7:0]};
        end
        else if (take2)
        begin
            dst_addr12 <= insn[11:0];
            dst_offset <= insn[6:0];
            if (pend_ff == ofd_pkg::PK_LDPTR)
                lit12 <= {hold_ff[3:0], insn[7:0]};
            if (pend_ff == ofd_pkg::PK_LIT20)
                lit20 <= {insn[11:0], hold_ff[7:0]};
        end
    end

    // ************************************************************
    // Table unit
    // ************************************************************
    ofd_table_pointer u_table_pointer (
        .clk     (clk),
        .rstn    (rstn),
        .ce      (ce),
        .step    (take && is_tbl),
        .mode    (ofd_pkg::ofd_tpmode_t'(insn[1:0])),
        .wr_en   (apb_wr && (paddr == ofd_pkg::OFF_TPTR)),
        .wr_data (pwdata[20:0]),
        .ptr_ff  (tptr),
        .addr_ff (tbl_addr)
    );

    // Table request pulse and direction
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            tbl_req      <= 1'b0;
            tbl_is_write <= 1'b0;
        end
        else if (ce)
        begin
            tbl_req      <= take && is_tbl;
            tbl_is_write <= take && is_tbl ? insn[2] : tbl_is_write;
        end
    end

    // Table latch: memory read data wins over a software write
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            table_latch <= ofd_pkg::RST_TLATCH;
        else if (ce && tbl_rd_valid)
            table_latch <= tbl_rd_data;
        else if (apb_wr && (paddr == ofd_pkg::OFF_TLATCH))
            table_latch <= pwdata[7:0];
    end

    // ************************************************************
    // Status flags
    // ************************************************************
    // Each flag follows its input while its write enable is high
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            flags <= ofd_pkg::RST_FLAGS;
        else if (ce)
            flags <= (flags & ~flag_we) | (flag_in & flag_we);
    end

    // ************************************************************
    // APB slave
    // ************************************************************
    assign apb_setup = ce && psel && !penable;
    assign apb_wr    = ce && psel && penable && pwrite;
    assign pready    = ce;
    assign addr_ok   = (paddr == ofd_pkg::OFF_BANK) || (paddr == ofd_pkg::OFF_TPTR) ||
                       (paddr == ofd_pkg::OFF_TLATCH) || (paddr == ofd_pkg::OFF_FLAGS) ||
                       (paddr == ofd_pkg::OFF_DSTAT);
    assign pslverr   = psel && penable && !addr_ok;

    // Bank select register steers banked RAM addresses
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            bank_ff <= ofd_pkg::RST_BANK;
        else if (apb_wr && (paddr == ofd_pkg::OFF_BANK))
            bank_ff <= pwdata[3:0];
    end

    // Read mux, unmapped addresses read as zero
    always_comb
    begin
        nxt_prdata = 32'h00000000;
        if (paddr == ofd_pkg::OFF_BANK)
            nxt_prdata = {28'h0000000, bank_ff};
        else if (paddr == ofd_pkg::OFF_TPTR)
            nxt_prdata = {11'h000, tptr};
        else if (paddr == ofd_pkg::OFF_TLATCH)
            nxt_prdata = {24'h000000, table_latch};
        else if (paddr == ofd_pkg::OFF_FLAGS)
            nxt_prdata = {27'h0000000, flags};
        else if (paddr == ofd_pkg::OFF_DSTAT)
            nxt_prdata = {28'h0000000, second_err, nop_word, state_ff};
    end

    // Read data captured in the setup cycle
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            prdata <= 32'h00000000;
        else if (apb_setup)
            prdata <= nxt_prdata;
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    property p_access_bank;
        take && !insn[8] |=> ram_addr[11:8] == ofd_pkg::ACCESS_BANK;
    endproperty
    a_access_bank: assert property (p_access_bank) else $error("access bank not used");

    property p_banked;
        take && insn[8] |=> ram_addr[11:8] == $past(bank_ff);
    endproperty
    a_banked: assert property (p_banked) else $error("bank register not used");

    property p_bit_sel;
        take |=> bit_sel == (8'h01 << $past(insn[11:9]));
    endproperty
    a_bit_sel: assert property (p_bit_sel) else $error("wrong bit selected");

    property p_dest;
        take |=> dest_is_file == $past(insn[9]) && file_addr == $past(insn[7:0]);
    endproperty
    a_dest: assert property (p_dest) else $error("destination or file field wrong");

    sequence s_movff_first;
        take && is_movff;
    endsequence
    sequence s_movff_second;
        ##1 (state_ff == ofd_pkg::ST_SECOND && !fields_valid);
    endsequence
    property p_movff_pair;
        s_movff_first |-> s_movff_second;
    endproperty
    a_movff_pair: assert property (p_movff_pair) else $error("move did not wait for second word");

    property p_movff_dst;
        take2 && pend_ff == ofd_pkg::PK_MOVFF |=> fields_valid && dst_addr12 == $past(insn[11:0]);
    endproperty
    a_movff_dst: assert property (p_movff_dst) else $error("destination address wrong");

    property p_lone_second;
        take && is_second |=> nop_word && fields_valid;
    endproperty
    a_lone_second: assert property (p_lone_second) else $error("lone second word not a no-op");

    property p_lit20;
        take2 && pend_ff == ofd_pkg::PK_LIT20 |=> lit20 == {$past(insn[11:0]), $past(hold_ff[7:0])};
    endproperty
    a_lit20: assert property (p_lit20) else $error("20-bit literal wrong");

    property p_rel_sign;
        take |=> rel_long[20:11] == {10{$past(insn[10])}};
    endproperty
    a_rel_sign: assert property (p_rel_sign) else $error("relative offset not sign extended");

    property p_fast;
        take && is_call |=> fast_mode == $past(insn[8]);
    endproperty
    a_fast: assert property (p_fast) else $error("fast bit wrong on call");

    property p_preinc;
        take && is_tbl && insn[1:0] == 2'h3 |=> tbl_req && tbl_addr == 21'($past(tptr) + 21'h1);
    endproperty
    a_preinc: assert property (p_preinc) else $error("pre-increment address wrong");

    property p_flags;
        ce && flag_we[ofd_pkg::FLG_ZERO] |=> flags[ofd_pkg::FLG_ZERO] == $past(flag_in[ofd_pkg::FLG_ZERO]);
    endproperty
    a_flags: assert property (p_flags) else $error("zero flag not updated");
endmodule // ofd_decoder

//--- tb/ofd_fetch_model.sv
// Fetch-side model that answers table reads with one byte of program memory
`timescale 1ns/1ps
module ofd_fetch_model (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // Table request from the decoder
    input  wire logic        tbl_req,
    input  wire logic        tbl_is_write,
    input  wire logic [20:0] tbl_addr,
    // Read answer
    output logic             tbl_rd_valid,
    output logic [7:0]       tbl_rd_data
);
    // Byte is derived from the address; between answers the data keeps toggling
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            tbl_rd_valid <= 1'b0;
            tbl_rd_data  <= 8'h00;
        end
        else
        begin
            tbl_rd_valid <= tbl_req & ~tbl_is_write;
            tbl_rd_data  <= tbl_req ? (tbl_addr[7:0] ^ 8'h5a) : ~tbl_rd_data;
        end
    end
endmodule // ofd_fetch_model

//--- tb/operand_field_decoder_bench.sv
// Self-checking bench for the operand field decoder
`timescale 1ns/1ps
module operand_field_decoder_bench;
    logic        clk = 0, rstn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0, insn_valid = 0;
    logic        pready, pslverr, fields_valid, nop_word, dest_is_file, tbl_req, tbl_is_write, tbl_rd_valid, e;
    logic        second_err, fast_mode;
    logic [1:0]  ptr_sel;
    logic [6:0]  src_offset, dst_offset;
    logic [19:0] lit20;
    logic [11:0] paddr = 0, ram_addr, src_addr12, dst_addr12, lit12;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [15:0] insn = 0, w;
    logic [7:0]  file_addr, bit_sel, lit8, tbl_rd_data, table_latch;
    logic [20:0] rel_long, rel_short, tbl_addr, ptr, ta;
    logic [4:0]  flag_we = 0, flag_in = 0, flags, fl;
    int          mismatches = 0, compares = 0, cyc = 0, i;
    ofd_decoder uut (.clk, .rstn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .insn_valid, .insn, .fields_valid, .nop_word, .second_err, .ram_addr, .file_addr, .dest_is_file,
        .bit_sel, .ptr_sel, .src_addr12, .dst_addr12, .lit8, .lit12, .lit20, .rel_long, .rel_short,
        .fast_mode, .src_offset, .dst_offset, .tbl_req, .tbl_is_write, .tbl_addr, .tbl_rd_valid,
        .tbl_rd_data, .table_latch, .flag_we, .flag_in, .flags);
    ofd_fetch_model fm (.clk, .rstn, .tbl_req, .tbl_is_write, .tbl_addr, .tbl_rd_valid, .tbl_rd_data);
    always #5 clk = ~clk;
    // Value compare, counted
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    // One APB transfer; holds the request until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1;
        penable <= 0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    // One instruction word; returns just after the decode result settles
    task automatic send(input logic [15:0] v);
        @(posedge clk);
        insn <= v;
        insn_valid <= 1;
        @(posedge clk);
        insn_valid <= 0;
        #1;
    endtask
    // Pointer after a table operation
    function automatic logic [20:0] pnext(input logic [20:0] p, input int m);
        return m == 0 ? p : m == 2 ? p - 21'h1 : p + 21'h1;
    endfunction
    task automatic finish_test;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Hang guard
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            mismatches++;
            finish_test;
        end
    end
    initial
    begin
        void'($urandom(32'h00cdef36));
        repeat (5) @(posedge clk);
        rstn <= 1;
        apb(1, ofd_pkg::OFF_BANK, 32'h5);
        apb(0, ofd_pkg::OFF_BANK, 0);
        chk("bank", 5, rd);
        apb(0, 12'h0fc, 0);
        chk("slverr", 1, e);
        chk("rdzero", 0, rd);
        $display("register test done");
        // Byte, bit, literal and branch fields from random words
        for (i = 0; i < 16; i++)
        begin
            w = {6'h09, i[1:0], 8'($urandom)};
            send(w);
            chk("valid", 1, fields_valid);
            chk("ram", {w[8] ? 4'h5 : ofd_pkg::ACCESS_BANK, w[7:0]}, ram_addr);
            chk("dest", w[9], dest_is_file);
            chk("file", w[7:0], file_addr);
            chk("lit8", w[7:0], lit8);
            w = {4'h8, i[2:0], 9'($urandom)};
            send(w);
            chk("bit", 8'h1 << i[2:0], bit_sel);
            chk("rel11", {{10{w[10]}}, w[10:0]}, rel_long);
            chk("rel8", {{13{w[7]}}, w[7:0]}, rel_short);
        end
        $display("field test done");
        // Two-word move, then a lone second word
        w = {4'hc, 12'($urandom)};
        send(w);
        chk("early", 0, fields_valid);
        chk("srcoff", w[6:0], src_offset);
        apb(0, ofd_pkg::OFF_DSTAT, 0);
        chk("dstat", 2, rd);
        send(16'hffff);
        chk("src", w[11:0], src_addr12);
        chk("dst", 12'hfff, dst_addr12);
        chk("dstoff", 7'h7f, dst_offset);
        send(16'hf000 | 16'($urandom));
        chk("nop", 1, nop_word);
        // Goto, call, return and pointer load fields, then a bad second word
        w = {8'hef, 8'($urandom)};
        send(w);
        send(16'hf9a4);
        chk("lit20", {12'h9a4, w[7:0]}, lit20);
        send({8'hed, 8'($urandom)});
        chk("fastcall", 1, fast_mode);
        send(16'hf000);
        send(16'h0012);
        chk("fastret", 0, fast_mode);
        send(16'hee2a);
        chk("ptrsel", 2, ptr_sel);
        send(16'hf05c);
        chk("lit12", 12'ha5c, lit12);
        send(16'hc000);
        send(16'h1234);
        chk("serr", 1, second_err);
        $display("two-word test done");
        // All four pointer modes, odd ones at the top of the pointer range
        for (i = 0; i < 4; i++)
        begin
            ptr = i[0] ? 21'h1fffff : 21'($urandom);
            ta = i == 3 ? pnext(ptr, i) : ptr;
            apb(1, ofd_pkg::OFF_TPTR, 32'(ptr));
            send(16'h0008 | 16'(i));
            chk("treq", 1, tbl_req);
            chk("taddr", ta, tbl_addr);
            repeat (2) @(posedge clk);
            #1;
            chk("latch", ta[7:0] ^ 8'h5a, table_latch);
            apb(0, ofd_pkg::OFF_TPTR, 0);
            chk("tptr", 32'(pnext(ptr, i)), rd);
        end
        apb(1, ofd_pkg::OFF_TLATCH, 32'hc3);
        apb(0, ofd_pkg::OFF_TLATCH, 0);
        chk("tlatch", 32'hc3, rd);
        send(16'h000c);
        chk("twrite", 1, tbl_is_write);
        repeat (2) @(posedge clk);
        #1;
        chk("latchhold", 8'hc3, table_latch);
        $display("table test done");
        // Random flag writes with per-bit enables
        repeat (4)
        begin
            fl = flags;
            w = 16'($urandom);
            @(posedge clk);
            flag_we <= w[4:0];
            flag_in <= w[9:5];
            @(posedge clk);
            flag_we <= 0;
            #1;
            chk("flags", (fl & ~w[4:0]) | (w[9:5] & w[4:0]), flags);
        end
        $display("flag test done");
        // A low clock enable leaves the offered word untaken
        @(posedge clk);
        ce <= 0;
        send(16'h2a05);
        chk("frozen", 0, fields_valid);
        @(posedge clk);
        ce <= 1;
        $display("enable test done");
        finish_test;
    end
endmodule // operand_field_decoder_bench
